/* bpcs_far_bus.sv */
`timescale 1ns/1ps
// ==========================================================
// Primary bus wires with pull-ups and another agent on the parity wire.
module bpcs_far_bus (
	input wire logic clock,      // Clock
	input wire logic pe_o,       // Parity pin level
	input wire logic pe_oe_n,    // Parity drive, low
	input wire logic se_o,       // Error pin level
	input wire logic se_oe_n,    // Error drive, low
	input wire logic ext_pe,     // Other agent pulls
	output logic     pe_wire,    // Parity wire
	output logic     se_wire,    // Error wire
	output logic     pin_seen    // Parity seen low
);
	// Released lines float high, so no old level lingers.
	assign pe_wire = !((!pe_oe_n && !pe_o) || ext_pe);
	assign se_wire = se_oe_n | se_o;
	// Sampled a cycle late, as a real receiver would.
	always_ff @(posedge clock) pin_seen <= !pe_wire;
endmodule // bpcs_far_bus

/* bpcs_pkg.sv */
// What this block does
// - Palette write: ports 3C6/3C8/3C9, upper half zero
// - Snoop enabled: claim and forward palette writes
// - Snoop disabled: claim palette only inside window
// - Parity response off: no pin, no data parity flag
// - Parity response on: drive pin, allow error
// - Wait cycle bit reads zero, no stepping
// - Error pin driven only when drive enabled
// - Fast back-to-back enable reads zero always
// - Reserved command and status bits read zero
// - Capability list flag reads one
// - Speed capable bit holds strap sampled after reset
// - Fast back-to-back capable bit reads one
// - Data parity flag needs master, error, response
// - Decode timing field reads 01b
// - Set signaled target abort on target abort
// - Set received target abort as master
// - Set received master abort as master
// - Set signaled error flag on pin assertion
// - Set detected parity flag on any data or address parity error
// - Writing one clears a flag, zero keeps
package bpcs_pkg;

	// ============================================================
	// Register placement
	localparam logic [7:0]  BPCS_CMD_STAT_DWORD = 8'h04;
	localparam logic [31:0] BPCS_RESERVED_VALUE = 32'h0000_0000;

	// ============================================================
	// Command field positions (dword bits)
	localparam int BPCS_CMD_SNOOP_BIT   = 5;
	localparam int BPCS_CMD_PARITY_BIT  = 6;
	localparam int BPCS_CMD_WAIT_BIT    = 7;
	localparam int BPCS_CMD_SERR_EN_BIT = 8;
	localparam int BPCS_CMD_FBB_EN_BIT  = 9;

	// ============================================================
	// Status field positions (dword bits)
	localparam int BPCS_ST_CAP_LIST_BIT = 20;
	localparam int BPCS_ST_SPEED_BIT    = 21;
	localparam int BPCS_ST_FBB_CAP_BIT  = 23;
	localparam int BPCS_ST_DPAR_BIT     = 24;
	localparam int BPCS_ST_DEVSEL_LO    = 25;
	localparam int BPCS_ST_SIG_TA_BIT   = 27;
	localparam int BPCS_ST_RCV_TA_BIT   = 28;
	localparam int BPCS_ST_RCV_MA_BIT   = 29;
	localparam int BPCS_ST_SIG_SE_BIT   = 30;
	localparam int BPCS_ST_DET_PE_BIT   = 31;

	// ============================================================
	// Fixed read values
	localparam logic       BPCS_WAIT_VALUE     = 1'b0;
	localparam logic       BPCS_FBB_EN_VALUE   = 1'b0;
	localparam logic       BPCS_CAP_LIST_VALUE = 1'b1;
	localparam logic       BPCS_FBB_CAP_VALUE  = 1'b1;
	localparam logic [1:0] BPCS_DEVSEL_VALUE   = 2'h1;

	// ============================================================
	// Reset values of writable state
	localparam logic BPCS_CTRL_RESET = 1'b0;
	localparam logic BPCS_FLAG_RESET = 1'b0;

	// ============================================================
	// Palette decode
	localparam logic [9:0]  BPCS_PAL_MASK_PORT = 10'h3C6;
	localparam logic [9:0]  BPCS_PAL_ADDR_PORT = 10'h3C8;
	localparam logic [9:0]  BPCS_PAL_DATA_PORT = 10'h3C9;
	localparam logic [15:0] BPCS_PAL_UPPER     = 16'h0000;

	// Sticky flag count and their byte lane.
	localparam int BPCS_NUM_FLAGS = 6;
	localparam int BPCS_FLAG_LANE = 3;
	localparam int BPCS_CTRL_LANE0 = 0;
	localparam int BPCS_CTRL_LANE1 = 1;

endpackage

/* bpcs_props.sv */
`timescale 1ns/1ps
// ==========================================================
// Port checker for the command and status bank.
module bpcs_props (
	input wire logic        clock,                         // Clock
	input wire logic        nrst,                          // Reset, low
	input wire logic [7:0]  cfg_dword_addr,                // Dword
	input wire logic [3:0]  primary_byte_enable_lines_n,   // Lanes
	input wire logic        cfg_ack,                       // Read ack
	input wire logic [31:0] cfg_rdata,                     // Read data
	input wire logic        io_wr,                         // I/O write
	input wire logic [31:0] io_addr,                       // I/O addr
	input wire logic        io_window_hit,                 // Window
	input wire logic        io_claim,                      // Claim
	input wire logic        palette_forward,               // Forward
	input wire logic        data_parity_err,               // Data error
	input wire logic        system_error_req,              // Error req
	input wire logic        primary_parity_error_pin_oe_n, // Drive
	input wire logic        primary_system_error_pin_oe_n, // Drive
	input wire logic        snoop_enable,                  // Snoop
	input wire logic        parity_response,               // Response
	input wire logic        system_error_drive_enable,     // Enable
	input wire logic        addr_data_stepping,            // Zero
	input wire logic        fast_b2b_generate              // Zero
);
	logic pal;
	// Bits 15:10 are left out so aliases of the ports also match.
	assign pal = io_wr && io_addr[31:16] == 16'h0000
		&& io_addr[9:0] inside {10'h3C6, 10'h3C8, 10'h3C9};
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	property p_snoop;
		snoop_enable |-> palette_forward == pal && (!pal || io_claim);
	endproperty
	a_snoop: assert property (p_snoop)
		else $error("palette write decode wrong");
	property p_no_snoop;
		!snoop_enable |-> !palette_forward
			&& io_claim == (io_wr && io_window_hit);
	endproperty
	a_no_snoop: assert property (p_no_snoop)
		else $error("claim without snoop wrong");
	property p_perr_off;
		!parity_response |=> primary_parity_error_pin_oe_n;
	endproperty
	a_perr_off: assert property (p_perr_off)
		else $error("parity pin driven while off");
	property p_perr_on;
		data_parity_err && parity_response |=> !primary_parity_error_pin_oe_n;
	endproperty
	a_perr_on: assert property (p_perr_on)
		else $error("parity pin not driven");
	property p_serr_off;
		!system_error_drive_enable |=> primary_system_error_pin_oe_n;
	endproperty
	a_serr_off: assert property (p_serr_off)
		else $error("error pin driven while off");
	property p_serr_on;
		system_error_req && system_error_drive_enable
			|=> !primary_system_error_pin_oe_n;
	endproperty
	a_serr_on: assert property (p_serr_on)
		else $error("error pin not driven");
	property p_fixed;
		cfg_ack && $past(primary_byte_enable_lines_n) == 4'h0
			&& $past(cfg_dword_addr) == 8'h04
			|-> (cfg_rdata & 32'h06DFFE80) == 32'h02900000;
	endproperty
	// Bit 21 follows the strap, so it is left out of the fixed mask.
	a_fixed: assert property (p_fixed)
		else $error("fixed read bits wrong");
	property p_no_step;
		!addr_data_stepping && !fast_b2b_generate;
	endproperty
	a_no_step: assert property (p_no_step)
		else $error("stepping or fast cycles enabled");
endmodule // bpcs_props

bind bpcs_regs bpcs_props bpcs_props_inst (.clock(clock), .nrst(nrst),
	.cfg_dword_addr(cfg_dword_addr), .cfg_ack(cfg_ack),
	.primary_byte_enable_lines_n(primary_byte_enable_lines_n),
	.cfg_rdata(cfg_rdata), .io_wr(io_wr), .io_addr(io_addr),
	.io_window_hit(io_window_hit), .io_claim(io_claim),
	.palette_forward(palette_forward), .data_parity_err(data_parity_err),
	.system_error_req(system_error_req),
	.primary_parity_error_pin_oe_n(primary_parity_error_pin_oe_n),
	.primary_system_error_pin_oe_n(primary_system_error_pin_oe_n),
	.snoop_enable(snoop_enable), .parity_response(parity_response),
	.system_error_drive_enable(system_error_drive_enable),
	.addr_data_stepping(addr_data_stepping),
	.fast_b2b_generate(fast_b2b_generate));

/* bpcs_regs.sv */
`timescale 1ns/1ps
module bpcs_regs (
	input  wire logic        clock,                      // 100 MHz bus clock
	input  wire logic        nrst,                       // Async reset, low
	// Configuration access
	input  wire logic        cfg_wr,                     // Config write
	input  wire logic        cfg_rd,                     // Config read
	input  wire logic [7:0]  cfg_dword_addr,             // Dword address
	input  wire logic [3:0]  primary_byte_enable_lines_n, // Lanes, low on
	input  wire logic [31:0] cfg_wdata,                  // Write data
	output logic             cfg_hit,                    // Address claimed
	output logic             cfg_ack,                    // Read data valid
	output logic [31:0]      cfg_rdata,                  // Read data
	// I/O write decode
	input  wire logic        io_wr,                      // I/O write seen
	input  wire logic [31:0] io_addr,                    // I/O address
	input  wire logic        io_window_hit,              // In I/O window
	output logic             io_claim,                   // Claim the cycle
	output logic             palette_forward,            // Forward palette
	// Primary bus events
	input  wire logic        is_primary_master,          // Acting as master
	input  wire logic        data_parity_err,            // Data parity err
	input  wire logic        addr_parity_err,            // Addr parity err
	input  wire logic        parity_pin_seen,            // Parity pin low
	input  wire logic        target_abort_sent,          // We target-aborted
	input  wire logic        target_abort_rcvd,          // We got target abt
	input  wire logic        master_abort_rcvd,          // We got master abt
	input  wire logic        system_error_req,           // Other error cause
	input  wire logic        speed_capability_strap,     // Speed strap pin
	// Pins
	output logic             primary_parity_error_pin_o,    // Pin level
	output logic             primary_parity_error_pin_oe_n, // Drive, low
	output logic             primary_system_error_pin_o,    // Pin level
	output logic             primary_system_error_pin_oe_n, // Drive, low
	// Control view for the rest of the bridge
	output logic             snoop_enable,               // Palette snoop
	output logic             parity_response,            // Parity response
	output logic             system_error_drive_enable,  // Error pin enable
	output logic             addr_data_stepping,         // Always zero
	output logic             fast_b2b_generate           // Always zero
);
	import bpcs_pkg::*;

	// ============================================================
	// Helpers

	// A lane takes part when its enable line is driven low.
	function automatic logic lane_on(input logic [3:0] be_n,
		input int lane);
		lane_on = ~be_n[lane];
	endfunction

	// Expand active lanes to a 32-bit bit mask.
	function automatic logic [31:0] lane_mask(input logic [3:0] be_n);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			if (lane_on(be_n, i)) begin
				m[i*8 +: 8] = 8'hFF;
			end
		end
		lane_mask = m;
	endfunction

	// ============================================================
	// Declarations
	logic        snoop_reg;
	logic        parity_resp_reg;
	logic        serr_en_reg;
	logic        speed_reg;
	logic        strap_taken_reg;
	logic        perr_drive_reg;
	logic        serr_drive_reg;
	logic        ack_reg;
	logic [31:0] rdata_reg;
	logic [BPCS_NUM_FLAGS-1:0] flag_reg;
	logic [BPCS_NUM_FLAGS-1:0] flag_set;
	logic [BPCS_NUM_FLAGS-1:0] flag_clr;
	logic        addr_match;
	logic        wr_hit;
	logic        is_palette;
	logic        serr_cause;
	logic        perr_cause;
	logic [31:0] dword_value;

	// Flag positions inside the dword, one per sticky flag.
	localparam int FLAG_POS [BPCS_NUM_FLAGS] = '{
		BPCS_ST_DPAR_BIT, BPCS_ST_SIG_TA_BIT, BPCS_ST_RCV_TA_BIT,
		BPCS_ST_RCV_MA_BIT, BPCS_ST_SIG_SE_BIT, BPCS_ST_DET_PE_BIT};

	// ============================================================
	// Configuration address decode

	// Only the command/status dword is ours; other dwords read zero
	// and leave cfg_hit low so another bank may answer.
	assign addr_match = (cfg_dword_addr == BPCS_CMD_STAT_DWORD);
	assign cfg_hit    = (cfg_wr | cfg_rd) & addr_match;
	assign wr_hit     = cfg_wr & addr_match;

	// ============================================================
	// Command controls

	// Lane 0 carries snoop and parity response; the wait bit in the
	// same lane is not stored, so a write of one there is dropped.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			snoop_reg       <= BPCS_CTRL_RESET;
			parity_resp_reg <= BPCS_CTRL_RESET;
		end else if (wr_hit &&
			lane_on(primary_byte_enable_lines_n, BPCS_CTRL_LANE0)) begin
			snoop_reg       <= cfg_wdata[BPCS_CMD_SNOOP_BIT];
			parity_resp_reg <= cfg_wdata[BPCS_CMD_PARITY_BIT];
		end
	end

	// Lane 1 carries the error pin drive enable; bits 15:9 are read
	// only and writes to them are discarded.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			serr_en_reg <= BPCS_CTRL_RESET;
		end else if (wr_hit &&
			lane_on(primary_byte_enable_lines_n, BPCS_CTRL_LANE1)) begin
			serr_en_reg <= cfg_wdata[BPCS_CMD_SERR_EN_BIT];
		end
	end

	assign snoop_enable              = snoop_reg;
	assign parity_response           = parity_resp_reg;
	assign system_error_drive_enable = serr_en_reg;
	// The bridge never steps nor issues fast back-to-back cycles.
	assign addr_data_stepping        = BPCS_WAIT_VALUE;
	assign fast_b2b_generate         = BPCS_FBB_EN_VALUE;

	// ============================================================
	// Speed strap capture

	// The strap is caught on the first edge after reset release and
	// then held, so a pin that wanders later cannot change the bit.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			speed_reg       <= 1'b0;
			strap_taken_reg <= 1'b0;
		end else if (!strap_taken_reg) begin
			speed_reg       <= speed_capability_strap;
			strap_taken_reg <= 1'b1;
		end
	end

	// ============================================================
	// Palette decode and claim

	// Bits 15:10 are deliberately left out of the compare.
	assign is_palette = (io_addr[31:16] == BPCS_PAL_UPPER) &&
		((io_addr[9:0] == BPCS_PAL_MASK_PORT) ||
		 (io_addr[9:0] == BPCS_PAL_ADDR_PORT) ||
		 (io_addr[9:0] == BPCS_PAL_DATA_PORT));

	// With snoop on every palette write is claimed; with it off a
	// palette write is claimed only as an ordinary window hit.
	assign palette_forward = io_wr & is_palette & snoop_reg;
	assign io_claim = io_wr & (io_window_hit |
		(is_palette & snoop_reg));

	// ============================================================
	// Error pins

	// The parity pin follows a data parity error only when response
	// is enabled; address errors reach the error pin on the same
	// condition, and the pin needs its drive enable as well.
	assign perr_cause = data_parity_err & parity_resp_reg;
	assign serr_cause = serr_en_reg & (system_error_req |
		(addr_parity_err & parity_resp_reg));

	// Pins are registered one cycle after the cause to keep them
	// glitch free; the value driven is always low.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			perr_drive_reg <= 1'b0;
		end else begin
			perr_drive_reg <= perr_cause;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			serr_drive_reg <= 1'b0;
		end else begin
			serr_drive_reg <= serr_cause;
		end
	end

	assign primary_parity_error_pin_o    = 1'b0;
	assign primary_parity_error_pin_oe_n = ~perr_drive_reg;
	assign primary_system_error_pin_o    = 1'b0;
	assign primary_system_error_pin_oe_n = ~serr_drive_reg;

	// ============================================================
	// Sticky status flags

	// Set causes, in the order of FLAG_POS.
	assign flag_set[0] = is_primary_master &
		(parity_pin_seen | data_parity_err) & parity_resp_reg;
	assign flag_set[1] = target_abort_sent;
	assign flag_set[2] = is_primary_master & target_abort_rcvd;
	assign flag_set[3] = is_primary_master & master_abort_rcvd;
	assign flag_set[4] = serr_drive_reg;
	assign flag_set[5] = data_parity_err | addr_parity_err;

	// One flop per flag; all flags sit in the top byte lane.
	generate
		for (genvar g = 0; g < BPCS_NUM_FLAGS; g++) begin : g_flag
			assign flag_clr[g] = wr_hit &
				lane_on(primary_byte_enable_lines_n, BPCS_FLAG_LANE) &
				cfg_wdata[FLAG_POS[g]];

			// A set arriving with a clear wins, so no event is lost.
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					flag_reg[g] <= BPCS_FLAG_RESET;
				end else if (flag_set[g]) begin
					flag_reg[g] <= 1'b1;
				end else if (flag_clr[g]) begin
					flag_reg[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ============================================================
	// Read view

	// Command bits 4:0 belong to another bank and read zero here.
	always_comb begin
		dword_value = BPCS_RESERVED_VALUE;
		dword_value[BPCS_CMD_SNOOP_BIT]    = snoop_reg;
		dword_value[BPCS_CMD_PARITY_BIT]   = parity_resp_reg;
		dword_value[BPCS_CMD_WAIT_BIT]     = BPCS_WAIT_VALUE;
		dword_value[BPCS_CMD_SERR_EN_BIT]  = serr_en_reg;
		dword_value[BPCS_CMD_FBB_EN_BIT]   = BPCS_FBB_EN_VALUE;
		dword_value[BPCS_ST_CAP_LIST_BIT]  = BPCS_CAP_LIST_VALUE;
		dword_value[BPCS_ST_SPEED_BIT]     = speed_reg;
		dword_value[BPCS_ST_FBB_CAP_BIT]   = BPCS_FBB_CAP_VALUE;
		dword_value[BPCS_ST_DEVSEL_LO +: 2] = BPCS_DEVSEL_VALUE;
		for (int i = 0; i < BPCS_NUM_FLAGS; i++) begin
			dword_value[FLAG_POS[i]] = flag_reg[i];
		end
	end

	// Read data is registered; lanes not enabled read as zero so a
	// partial read shows only the fields it asked for.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (cfg_rd) begin
			rdata_reg <= addr_match ?
				(dword_value & lane_mask(primary_byte_enable_lines_n)) :
				BPCS_RESERVED_VALUE;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= cfg_rd;
		end
	end

	assign cfg_rdata = rdata_reg;
	assign cfg_ack   = ack_reg;

endmodule // bpcs_regs

/* bpcs_regs_test.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the command and status bank.
module bpcs_regs_test;
	typedef struct {logic [31:0] d; logic [3:0] w, r; logic [31:0] e;} bpcs_row_t;
	logic clock, nrst, cfg_wr, cfg_rd, io_wr, win, master, strap, ext_pe;
	logic hit, ack, claim, fwd, pe_o, pe_oe, se_o, se_oe, seen, pw, sw;
	logic snoop, presp, sen, step, fbb;
	logic [7:0] addr;
	logic [3:0] be_n;
	logic [5:0] ev;
	logic [31:0] wdata, io_addr, rdata;
	int err_total, compares, cyc;
	bpcs_row_t rows [5] = '{'{32'hFFFFFFFF, 4'h0, 4'h0, 32'h02B00160},
		'{32'h00000000, 4'h0, 4'h0, 32'h02B00000},
		'{32'h0000FFFF, 4'hE, 4'h0, 32'h02B00060},
		'{32'h00000100, 4'hD, 4'hC, 32'h00000160},
		'{32'h00000000, 4'h0, 4'h3, 32'h02B00000}};
	logic [31:0] pa [5] = '{32'h3C6, 32'hFFC8, 32'h3C9, 32'h3C7, 32'h103C6};
	bpcs_regs bpcs_regs_inst (.clock(clock), .nrst(nrst), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_dword_addr(addr), .cfg_wdata(wdata),
		.primary_byte_enable_lines_n(be_n), .cfg_hit(hit), .cfg_ack(ack),
		.cfg_rdata(rdata), .io_wr(io_wr), .io_addr(io_addr),
		.io_window_hit(win), .io_claim(claim), .palette_forward(fwd),
		.is_primary_master(master), .data_parity_err(ev[0]),
		.addr_parity_err(ev[1]), .parity_pin_seen(seen),
		.target_abort_sent(ev[2]), .target_abort_rcvd(ev[3]),
		.master_abort_rcvd(ev[4]), .system_error_req(ev[5]),
		.speed_capability_strap(strap), .primary_parity_error_pin_o(pe_o),
		.primary_parity_error_pin_oe_n(pe_oe), .snoop_enable(snoop),
		.primary_system_error_pin_o(se_o), .parity_response(presp),
		.primary_system_error_pin_oe_n(se_oe), .fast_b2b_generate(fbb),
		.system_error_drive_enable(sen), .addr_data_stepping(step));
	bpcs_far_bus bpcs_far_bus_inst (.clock(clock), .pe_o(pe_o),
		.pe_oe_n(pe_oe), .se_o(se_o), .se_oe_n(se_oe), .ext_pe(ext_pe),
		.pe_wire(pw), .se_wire(sw), .pin_seen(seen));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// A hang costs one mismatch and still reaches the report.
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// Lanes are picked by driving their enables low.
	task automatic acc(logic w, logic [7:0] a, logic [3:0] b, logic [31:0] d);
		@(posedge clock);
		cfg_wr <= w;
		cfg_rd <= !w;
		addr <= a;
		be_n <= b;
		wdata <= d;
		#1;
		chk("hit", hit, a == 8'h04);
		@(posedge clock);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b0;
		#1;
		if (!w) chk("ack", ack, 1);
		if (!w) chk("read data", rdata, d);
	endtask
	task automatic pulse(logic [5:0] v);
		@(posedge clock);
		ev <= v;
		@(posedge clock);
		ev <= 6'h00;
	endtask
	task automatic io(logic [31:0] a, logic w, logic c, logic f);
		@(posedge clock);
		io_addr <= a;
		win <= w;
		@(negedge clock);
		chk("claim", claim, c);
		chk("forward", fwd, f);
	endtask
	initial begin
		{nrst, cfg_wr, cfg_rd, io_wr, win, master, ext_pe, addr, ev} = '0;
		{wdata, io_addr, strap, be_n} = {64'h0, 1'b1, 4'hF};
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		acc(0, 8'h04, 4'h0, 32'h02B00000);
		foreach (rows[i]) begin
			acc(1, 8'h04, rows[i].w, rows[i].d);
			acc(0, 8'h04, rows[i].r, rows[i].e);
		end
		acc(1, 8'h08, 4'h0, 32'hFFFFFFFF);
		acc(0, 8'h08, 4'h0, 32'h0);
		acc(0, 8'h04, 4'h0, 32'h02B00000);
		acc(1, 8'h04, 4'h0, 32'h20);
		io_wr <= 1'b1;
		foreach (pa[i]) io(pa[i], 0, i < 3, i < 3);
		acc(1, 8'h04, 4'h0, 32'h0);
		io(32'h3C6, 0, 0, 0);
		io(32'h3C6, 1, 1, 0);
		io_wr <= 1'b0;
		acc(1, 8'h04, 4'h0, 32'h160);
		master <= 1'b1;
		foreach (ev[i]) if (i != 1) pulse(6'h01 << i);
		acc(0, 8'h04, 4'h0, 32'hFBB00160);
		acc(1, 8'h04, 4'h0, 32'h01000160);
		acc(0, 8'h04, 4'h0, 32'hFAB00160);
		acc(1, 8'h04, 4'h0, 32'hFA000160);
		master <= 1'b0;
		pulse(6'h01);
		#1;
		chk("wires", {pw, sw}, 2'b01);
		acc(0, 8'h04, 4'h0, 32'h82B00160);
		acc(1, 8'h04, 4'h0, 32'h80000000);
		master <= 1'b1;
		pulse(6'h23);
		#1;
		chk("wires", {pw, sw}, 2'b11);
		acc(0, 8'h04, 4'h0, 32'h82B00000);
		acc(1, 8'h04, 4'h0, 32'h80000040);
		@(posedge clock);
		ext_pe <= 1'b1;
		@(posedge clock);
		ext_pe <= 1'b0;
		fork
			pulse(6'h04);
			acc(1, 8'h04, 4'h0, 32'h08000040);
		join
		acc(0, 8'h04, 4'h0, 32'h0BB00040);
		nrst <= 1'b0;
		strap <= 1'b0;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		acc(0, 8'h04, 4'h0, 32'h02900000);
		complete_run();
	end
endmodule // bpcs_regs_test
